// ### src/ddrrd_defs.vh
`ifndef DDRRD_DEFS_VH
`define DDRRD_DEFS_VH

// Register byte offsets.
`define DDRRD_OFS_MODE      8'h00
`define DDRRD_OFS_LAT       8'h04
`define DDRRD_OFS_DATA      8'h08
`define DDRRD_OFS_STATUS    8'h0C
`define DDRRD_OFS_LEVEL     8'h10

// Burst field encodings.
`define DDRRD_BURST_FIX8    2'h0
`define DDRRD_BURST_SEL     2'h1
`define DDRRD_BURST_FIX4    2'h2

// Latency register field positions.
`define DDRRD_LAT_CL_LSB    0
`define DDRRD_LAT_AL_LSB    6
`define DDRRD_LAT_CWL_LSB   12
`define DDRRD_LAT_WPRE_LSB  18
`define DDRRD_LAT_WTRL_LSB  20
`define DDRRD_LAT_WTRS_LSB  24

// Status register field positions.
`define DDRRD_ST_BUSY       0
`define DDRRD_ST_LOCKED     1
`define DDRRD_ST_UNDERRUN   2
`define DDRRD_ST_R2W        3
`define DDRRD_ST_W2R        4
`define DDRRD_ST_NOLOCK     5
`define DDRRD_ST_BANK_LSB   16

// Reset values.
`define DDRRD_RST_MODE      2'h0
`define DDRRD_RST_LAT       28'h2209_24B

// Command address bit positions.
`define DDRRD_A_AUTOCLOSE   10
`define DDRRD_A_BURST       12

// Beat counts per burst.
`define DDRRD_BEATS_FULL    4'h8
`define DDRRD_BEATS_CHOP    4'h4

`endif

// ### src/ddrrd_sync.v
`timescale 1ns/1ns
module ddrrd_sync #(
    parameter W = 1
) (
    // Clock and reset.
    input  wire         i_sys_clk,
    input  wire         i_arst_n,
    // Asynchronous input and its synchronised copy.
    input  wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);

reg [W-1:0] stage1;
reg [W-1:0] stage2;

// Two flops; the first is read only by the second to keep metastability contained.
always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
        stage1 <= {W{1'b0}};
        stage2 <= {W{1'b0}};
    end else begin
        stage1 <= i_async;
        stage2 <= stage1;
    end
end

assign o_sync = stage2;

endmodule

// ### src/ddrrd_fifo.v
`timescale 1ns/1ns
module ddrrd_fifo #(
    parameter W  = 32,
    parameter D  = 32,
    parameter AW = 5
) (
    // Clock and reset.
    input  wire          i_sys_clk,
    input  wire          i_arst_n,
    // Fill side.
    input  wire          i_wr_valid,
    output wire          o_wr_ready,
    input  wire [W-1:0]  i_wr_data,
    // Drain side.
    output wire          o_rd_valid,
    input  wire          i_rd_ready,
    output wire [W-1:0]  o_rd_data,
    // Fill level.
    output wire [AW:0]   o_level
);

reg [W-1:0]  mem [0:D-1];
reg [AW-1:0] wr_ptr;
reg [AW-1:0] rd_ptr;
reg [AW:0]   count;

wire push = i_wr_valid & o_wr_ready;
wire pop  = o_rd_valid & i_rd_ready;

assign o_wr_ready = (count != D[AW:0]);
assign o_rd_valid = (count != {(AW+1){1'b0}});
assign o_rd_data  = mem[rd_ptr];
assign o_level    = count;

// Storage carries no reset; only the pointers and the count define what is valid.
always @(posedge i_sys_clk) begin
    if (push) begin
        mem[wr_ptr] <= i_wr_data;
    end
end

// Pointers wrap at the depth so depths that are not powers of two still work.
always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
        wr_ptr <= {AW{1'b0}};
        rd_ptr <= {AW{1'b0}};
        count  <= {(AW+1){1'b0}};
    end else begin
        if (push) begin
            wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
        end
        if (pop) begin
            rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end
end

endmodule

// ### src/ddrrd_read_burst.v
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
`include "ddrrd_defs.vh"

// Notes on behaviour
// - Reads are served only while the delay-locked loop reports locked.
// - In per-command mode, address bit 12 low chops to four beats, high gives eight.
// - Eight beats for fixed-eight mode, or per-command mode with bit 12 high.
// - Address bit 10 high closes the bank after the burst unless the next burst starts on that rise; low leaves it open.
// - After eight beats the data pins are released at the fourth rise after latency.
// - After four beats the data pins are released at the second rise after latency.
module ddrrd_read_burst #(
    parameter DW    = 8,
    parameter FIFOD = 32,
    parameter FAW   = 5,
    parameter QD    = 4,
    parameter QAW   = 2,
    parameter RLMAX = 64
) (
    // System clock and reset.
    input  wire             i_sys_clk,
    input  wire             i_arst_n,
    // Register port.
    input  wire [7:0]       i_reg_addr,
    input  wire [31:0]      i_reg_wdata,
    input  wire             i_reg_wr,
    input  wire             i_reg_rd,
    output reg  [31:0]      o_reg_rdata,
    // Command bus from the controller, sampled on link clock rises.
    input  wire             i_ck,
    input  wire             i_cmd_act,
    input  wire             i_cmd_rd,
    input  wire             i_cmd_wr,
    input  wire [13:0]      i_addr,
    input  wire [3:0]       i_bank,
    input  wire             i_dll_locked,
    // Data and strobe pins, enables low while driving.
    output reg  [DW-1:0]    o_dq,
    output reg              o_dq_oe_n,
    output reg              o_dqs,
    output reg              o_dqs_oe_n,
    output reg  [2:0]       o_beat_col,
    // Buffer back-pressure.
    output wire             o_data_space
);

// Synchronised link inputs.
wire        ck_s;
wire        act_s;
wire        rd_s;
wire        wr_s;
wire [13:0] addr_s;
wire [3:0]  bank_s;
wire        locked_s;

ddrrd_sync #(.W(23)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_async   ({i_ck, i_cmd_act, i_cmd_rd, i_cmd_wr, i_addr, i_bank, i_dll_locked}),
    .o_sync    ({ck_s, act_s, rd_s, wr_s, addr_s, bank_s, locked_s})
);

// Edge finder on the synchronised link clock.
reg  ck_d;
wire ck_rise = ck_s & ~ck_d;
wire ck_fall = ~ck_s & ck_d;

always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
        ck_d <= 1'b0;
    end else begin
        ck_d <= ck_s;
    end
end

// Software registers.
reg  [1:0]  burst_mode;
reg  [27:0] lat;
reg         st_underrun;
reg         st_r2w;
reg         st_w2r;
reg         st_nolock;
reg  [15:0] bank_open;
wire [5:0]  cl   = lat[`DDRRD_LAT_CL_LSB +: 6];
wire [5:0]  al   = lat[`DDRRD_LAT_AL_LSB +: 6];
wire [5:0]  cwl  = lat[`DDRRD_LAT_CWL_LSB +: 6];
wire [1:0]  wpre = lat[`DDRRD_LAT_WPRE_LSB +: 2];
wire [3:0]  wtrl = lat[`DDRRD_LAT_WTRL_LSB +: 4];
wire [3:0]  wtrs = lat[`DDRRD_LAT_WTRS_LSB +: 4];
wire [6:0]  rl   = {1'b0, al} + {1'b0, cl};

// Buffer between software writes and the burst engine.
wire          fifo_valid;
wire [DW-1:0] fifo_data;
wire [FAW:0]  fifo_level;
reg           beat_pop;
wire          data_wr = i_reg_wr && (i_reg_addr == `DDRRD_OFS_DATA);

ddrrd_fifo #(.W(DW), .D(FIFOD), .AW(FAW)) u_fifo (
    .i_sys_clk  (i_sys_clk),
    .i_arst_n   (i_arst_n),
    .i_wr_valid (data_wr),
    .o_wr_ready (o_data_space),
    .i_wr_data  (i_reg_wdata[DW-1:0]),
    .o_rd_valid (fifo_valid),
    .i_rd_ready (beat_pop),
    .o_rd_data  (fifo_data),
    .o_level    (fifo_level)
);

// Command decode on link clock rises.
wire rd_take  = ck_rise & rd_s & locked_s;
wire rd_drop  = ck_rise & rd_s & ~locked_s;
wire wr_take  = ck_rise & wr_s;
wire act_take = ck_rise & act_s;
wire rd_chop  = (burst_mode == `DDRRD_BURST_FIX4) ||
                ((burst_mode == `DDRRD_BURST_SEL) && !addr_s[`DDRRD_A_BURST]);
wire wr_chop  = (burst_mode == `DDRRD_BURST_FIX4);

// Pending read queue; entries leave in issue order as latency expires.
reg [8:0]     q_mem [0:QD-1];
reg [QAW-1:0] q_wr;
reg [QAW-1:0] q_rd;
reg [RLMAX-1:0] lat_line;
wire start = ck_rise && lat_line[rl[5:0] - 6'h01];
wire [8:0] q_head = q_mem[q_rd];

// The latency line shifts one place per link clock, so a marker reaches tap RL-1 after RL rises.
always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
        lat_line <= {RLMAX{1'b0}};
        q_wr     <= {QAW{1'b0}};
        q_rd     <= {QAW{1'b0}};
    end else begin
        if (ck_rise) begin
            lat_line <= {lat_line[RLMAX-2:0], rd_take};
        end
        if (rd_take) begin
            q_wr <= q_wr + 1'b1;
        end
        if (start) begin
            q_rd <= q_rd + 1'b1;
        end
    end
end

// Queue storage holds chop, close, start column and bank of each read.
always @(posedge i_sys_clk) begin
    if (rd_take) begin
        q_mem[q_wr] <= {rd_chop, addr_s[`DDRRD_A_AUTOCLOSE], addr_s[2:0], bank_s};
    end
end

// Burst engine state.
reg       active;
reg [3:0] beats_total;
reg [3:0] beat_cnt;
reg [2:0] col_base;
reg       close_bank;
reg [3:0] cur_bank;
wire      beat_rise = start || (ck_rise && active && (beat_cnt != beats_total));
wire      beat_fall = ck_fall && active && (beat_cnt != beats_total);
wire      burst_end = ck_rise && active && (beat_cnt == beats_total) && !start;
wire      emit      = beat_rise | beat_fall;

// Each emitted beat draws one buffer word; an empty buffer sends zero and is flagged.
always @* begin
    beat_pop = emit & fifo_valid;
end

// Beats leave on both link clock edges; pins are released on the rise after the last beat.
always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
        active      <= 1'b0;
        beats_total <= `DDRRD_BEATS_FULL;
        beat_cnt    <= 4'h0;
        col_base    <= 3'h0;
        close_bank  <= 1'b0;
        cur_bank    <= 4'h0;
        o_dq        <= {DW{1'b0}};
        o_dq_oe_n   <= 1'b1;
        o_dqs       <= 1'b0;
        o_dqs_oe_n  <= 1'b1;
        o_beat_col  <= 3'h0;
    end else begin
        if (start) begin
            active      <= 1'b1;
            beats_total <= q_head[8] ? `DDRRD_BEATS_CHOP : `DDRRD_BEATS_FULL;
            beat_cnt    <= 4'h1;
            col_base    <= q_head[6:4];
            close_bank  <= q_head[7];
            cur_bank    <= q_head[3:0];
            o_beat_col  <= q_head[6:4];
        end else if (burst_end) begin
            active <= 1'b0;
        end else if (emit) begin
            beat_cnt   <= beat_cnt + 4'h1;
            o_beat_col <= col_base + beat_cnt[2:0];
        end
        if (emit) begin
            o_dq       <= fifo_valid ? fifo_data : {DW{1'b0}};
            o_dqs      <= beat_rise;
            o_dq_oe_n  <= 1'b0;
            o_dqs_oe_n <= 1'b0;
        end else if (burst_end) begin
            o_dq_oe_n  <= 1'b1;
            o_dqs_oe_n <= 1'b1;
            o_dqs      <= 1'b0;
        end
    end
end

// Turnaround tracking counts link clocks since the last read and write, saturating.
reg [7:0] since_rd;
reg [7:0] since_wr;
reg       last_rd_chop;
reg       last_wr_chop;
reg [1:0] last_wr_group;
wire [8:0] r2w_need = {3'h0, cl} + (last_rd_chop ? 9'h002 : 9'h004) + 9'h001 +
                      {7'h00, wpre};
wire [8:0] r2w_have = {1'b0, since_rd} + {3'h0, cwl};
wire [3:0] wtr_use  = (bank_s[3:2] == last_wr_group) ? wtrl : wtrs;
wire [8:0] w2r_need = {3'h0, cwl} + (last_wr_chop ? 9'h002 : 9'h004) + {5'h00, wtr_use};
wire       r2w_bad  = wr_take && (r2w_have < r2w_need);
wire       w2r_bad  = rd_s && ck_rise && ({1'b0, since_wr} < w2r_need);

always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
        since_rd      <= 8'hFF;
        since_wr      <= 8'hFF;
        last_rd_chop  <= 1'b0;
        last_wr_chop  <= 1'b0;
        last_wr_group <= 2'h0;
    end else if (ck_rise) begin
        if (rd_take) begin
            since_rd     <= 8'h01;
            last_rd_chop <= rd_chop;
        end else if (since_rd != 8'hFF) begin
            since_rd <= since_rd + 8'h01;
        end
        if (wr_take) begin
            since_wr      <= 8'h01;
            last_wr_chop  <= wr_chop;
            last_wr_group <= bank_s[3:2];
        end else if (since_wr != 8'hFF) begin
            since_wr <= since_wr + 8'h01;
        end
    end
end

// Open banks: activate opens, a closing read shuts its bank when its burst ends unless the next burst starts on that rise.
always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
        bank_open <= 16'h0000;
    end else begin
        if (burst_end && close_bank) begin
            bank_open[cur_bank] <= 1'b0;
        end
        if (act_take) begin
            bank_open[bank_s] <= 1'b1;
        end
    end
end

// Register writes; a sticky flag set in the same cycle as its clear stays set.
wire st_wr = i_reg_wr && (i_reg_addr == `DDRRD_OFS_STATUS);
wire underrun_ev = emit & ~fifo_valid;

always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
        burst_mode  <= `DDRRD_RST_MODE;
        lat         <= `DDRRD_RST_LAT;
        st_underrun <= 1'b0;
        st_r2w      <= 1'b0;
        st_w2r      <= 1'b0;
        st_nolock   <= 1'b0;
    end else begin
        if (i_reg_wr && (i_reg_addr == `DDRRD_OFS_MODE)) begin
            burst_mode <= i_reg_wdata[1:0];
        end
        if (i_reg_wr && (i_reg_addr == `DDRRD_OFS_LAT)) begin
            lat <= i_reg_wdata[27:0];
        end
        st_underrun <= underrun_ev |
                       (st_underrun & ~(st_wr & i_reg_wdata[`DDRRD_ST_UNDERRUN]));
        st_r2w      <= r2w_bad | (st_r2w & ~(st_wr & i_reg_wdata[`DDRRD_ST_R2W]));
        st_w2r      <= w2r_bad | (st_w2r & ~(st_wr & i_reg_wdata[`DDRRD_ST_W2R]));
        st_nolock   <= rd_drop | (st_nolock & ~(st_wr & i_reg_wdata[`DDRRD_ST_NOLOCK]));
    end
end

// Read data is registered and stands only in the cycle after the strobe.
reg [31:0] next_rdata;

always @* begin
    next_rdata = 32'h0000_0000;
    case (i_reg_addr)
        `DDRRD_OFS_MODE: begin
            next_rdata[1:0] = burst_mode;
        end
        `DDRRD_OFS_LAT: begin
            next_rdata[27:0] = lat;
        end
        `DDRRD_OFS_STATUS: begin
            next_rdata[`DDRRD_ST_BUSY]     = active | (|lat_line);
            next_rdata[`DDRRD_ST_LOCKED]   = locked_s;
            next_rdata[`DDRRD_ST_UNDERRUN] = st_underrun;
            next_rdata[`DDRRD_ST_R2W]      = st_r2w;
            next_rdata[`DDRRD_ST_W2R]      = st_w2r;
            next_rdata[`DDRRD_ST_NOLOCK]   = st_nolock;
            next_rdata[`DDRRD_ST_BANK_LSB +: 16] = bank_open;
        end
        `DDRRD_OFS_LEVEL: begin
            next_rdata[FAW:0] = fifo_level;
        end
        default: begin
            next_rdata = 32'h0000_0000;
        end
    endcase
end

always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
        o_reg_rdata <= 32'h0000_0000;
    end else if (i_reg_rd) begin
        o_reg_rdata <= next_rdata;
    end else begin
        o_reg_rdata <= 32'h0000_0000;
    end
end

endmodule

// ### sim/ddrrd_chk.sv
`timescale 1ns/1ns
module ddrrd_chk (
    // Clock, reset and delay-locked loop status.
    input logic       i_sys_clk,
    input logic       i_arst_n,
    input logic       i_dll_locked,
    // Strobe and data pin controls.
    input logic       o_dq_oe_n,
    input logic       o_dqs,
    input logic       o_dqs_oe_n,
    input logic [2:0] o_beat_col
);
    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_arst_n);

    // Cycles the pins have been driven; back-to-back bursts would merge runs.
    logic [7:0] run;
    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n)
            run <= 8'h00;
        else
            run <= o_dq_oe_n ? 8'h00 : run + 8'h01;
    end

    property p_oe_pair;
        o_dqs_oe_n == o_dq_oe_n;
    endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("strobe and data enables differ");
    property p_idle_low;
        o_dqs_oe_n |-> !o_dqs;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("strobe high while released");
    property p_col_step;
        $fell(o_dqs) && !o_dq_oe_n |-> o_beat_col == $past(o_beat_col) + 3'h1;
    endproperty
    a_col_step: assert property (p_col_step) else $error("column did not advance");
    property p_col_hold;
        !o_dq_oe_n && !$past(o_dq_oe_n) && $stable(o_dqs) |-> $stable(o_beat_col);
    endproperty
    a_col_hold: assert property (p_col_hold) else $error("column moved mid beat");
    property p_beat_len;
        $rose(o_dqs) |-> o_dqs [*4] ##1 !o_dqs;
    endproperty
    a_beat_len: assert property (p_beat_len) else $error("beat not half a link clock");
    property p_first_rise;
        $fell(o_dq_oe_n) |-> o_dqs;
    endproperty
    a_first_rise: assert property (p_first_rise) else $error("burst began on fall beat");
    property p_release;
        $rose(o_dq_oe_n) |-> run == 8'd16 || run == 8'd32;
    endproperty
    a_release: assert property (p_release) else $error("pins released at wrong rise");
    property p_lock;
        $fell(o_dq_oe_n) |-> $past(i_dll_locked, 8);
    endproperty
    a_lock: assert property (p_lock) else $error("burst served while unlocked");

    c_short: cover property ($rose(o_dq_oe_n) && run == 8'd16);
    c_long: cover property ($rose(o_dq_oe_n) && run == 8'd32);
    c_wrap: cover property ($fell(o_dqs) && o_beat_col == 3'h0);
endmodule

bind ddrrd_read_burst ddrrd_chk u_chk (
    .i_sys_clk    (i_sys_clk),
    .i_arst_n     (i_arst_n),
    .i_dll_locked (i_dll_locked),
    .o_dq_oe_n    (o_dq_oe_n),
    .o_dqs        (o_dqs),
    .o_dqs_oe_n   (o_dqs_oe_n),
    .o_beat_col   (o_beat_col)
);

// ### sim/ddrrd_ctrl_model.sv
`timescale 1ns/1ns
module ddrrd_ctrl_model (
    // Link clock and command bus toward the device.
    output logic        o_ck,
    output logic        o_act,
    output logic        o_rd,
    output logic        o_wr,
    output logic [13:0] o_addr,
    output logic [3:0]  o_bank
);
    // Rise at which the last command was taken.
    time t_cmd;

    // The clock runs free, as a memory clock does; its edges fall between system
    // clock edges so the synchroniser never sees a same-time-step race.
    initial begin
        o_ck = 1'b0;
        {o_act, o_rd, o_wr} = 3'h0;
        o_addr = 14'h0000;
        o_bank = 4'h0;
        t_cmd = 0;
        #10;
        forever #200 o_ck = ~o_ck;
    end

    // One command around a rise; released address and bank lines show the inverse so stale values never pass.
    task send(input logic [2:0] kind, input logic [13:0] a, input logic [3:0] b);
        @(negedge o_ck);
        {o_act, o_rd, o_wr} <= kind;
        o_addr <= a;
        o_bank <= b;
        @(posedge o_ck);
        t_cmd = $time;
        @(negedge o_ck);
        {o_act, o_rd, o_wr} <= 3'h0;
        o_addr <= ~a;
        o_bank <= ~b;
    endtask

    // Command spacing is kept by waiting whole clocks between commands.
    task gap(input int n);
        repeat (n) @(posedge o_ck);
    endtask
endmodule

// ### sim/ddrrd_read_burst_tb_top.sv
`timescale 1ns/1ns
`include "ddrrd_defs.vh"
module ddrrd_read_burst_tb_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        dll = 1'b1;
    wire  [31:0] rdata;
    wire         ck, act, cmd_rd, cmd_wr, dq_oe_n, dqs, dqs_oe_n, space;
    wire  [13:0] addr;
    wire  [3:0]  bank;
    wire  [7:0]  dq;
    wire  [2:0]  col;
    int          err_count = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          idx = 0;

    ddrrd_read_burst DUT (
        .i_sys_clk(clk), .i_arst_n(rst_n), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
        .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(rdata), .i_ck(ck),
        .i_cmd_act(act), .i_cmd_rd(cmd_rd), .i_cmd_wr(cmd_wr), .i_addr(addr), .i_bank(bank),
        .i_dll_locked(dll), .o_dq(dq), .o_dq_oe_n(dq_oe_n), .o_dqs(dqs),
        .o_dqs_oe_n(dqs_oe_n), .o_beat_col(col), .o_data_space(space)
    );
    ddrrd_ctrl_model ctrl (.o_ck(ck), .o_act(act), .o_rd(cmd_rd), .o_wr(cmd_wr),
        .o_addr(addr), .o_bank(bank));

    // System clock of 20 MHz.
    always #25 clk = ~clk;

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task t_regs;
        logic [31:0] v;
        rd(`DDRRD_OFS_MODE, v);
        chk("mode", 32'h0, v);
        rd(`DDRRD_OFS_LAT, v);
        chk("latency reg", 32'h0220_924B, v);
        rd(8'h14, v);
        chk("unmapped", 32'h0, v);
        rd(`DDRRD_OFS_STATUS, v);
        chk("locked", 32'h1, {31'h0, v[`DDRRD_ST_LOCKED]});
        wr(`DDRRD_OFS_LAT, 32'h0124_2083);
        rd(`DDRRD_OFS_LAT, v);
        chk("latency wr", 32'h0124_2083, v);
        $display("test regs done");
    endtask

    // The 33rd word must be refused by the full buffer.
    task t_fill;
        logic [31:0] v;
        for (int i = 0; i < 33; i++)
            wr(`DDRRD_OFS_DATA, 32'h10 + i);
        rd(`DDRRD_OFS_LEVEL, v);
        chk("level", 32'h20, v);
        chk("space", 32'h0, {31'h0, space});
        $display("test fill done");
    endtask

    // Read latency is 5 link clocks (AL 2, CL 3) plus a few cycles of synchronising.
    task burst(input logic [13:0] a, input int nb);
        int n;
        time dt;
        ctrl.send(3'h2, a, 4'h9);
        n = 0;
        while (dq_oe_n !== 1'b0 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        dt = $time - ctrl.t_cmd;
        chk("latency", 32'h1, {31'h0, dt >= 2000 && dt <= 2300});
        for (int i = 0; i < nb; i++) begin
            chk("dq", idx < 32 ? 32'h10 + idx : 32'h0, {24'h0, dq});
            chk("col", (a[2:0] + i) % 8, {29'h0, col});
            chk("dqs", ~i & 1, {31'h0, dqs});
            idx++;
            repeat (4) @(posedge clk);
            #1;
        end
        chk("release", 32'h1, {31'h0, dq_oe_n});
    endtask

    // Every burst mode; the last burst drains an empty buffer and closes the bank.
    task t_modes;
        logic [1:0]  md [6];
        logic [13:0] ad [6];
        int          nb [6];
        logic [31:0] v;
        md = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h0, 2'h1};
        ad = '{14'h0005, 14'h0003, 14'h1007, 14'h1000, 14'h1002, 14'h0406};
        nb = '{8, 4, 8, 4, 8, 4};
        ctrl.send(3'h4, 14'h0000, 4'h9);
        for (int k = 0; k < 6; k++) begin
            wr(`DDRRD_OFS_MODE, {30'h0, md[k]});
            burst(ad[k], nb[k]);
            ctrl.gap(2);
            rd(`DDRRD_OFS_STATUS, v);
            chk("open bank", k < 5, {31'h0, v[25]});
        end
        chk("underrun", 32'h1, {31'h0, v[`DDRRD_ST_UNDERRUN]});
        $display("test modes done");
    endtask

    // Spacing exactly at the limit passes; commands two or three clocks apart are flagged.
    task t_turn;
        logic [31:0] v;
        wr(`DDRRD_OFS_STATUS, 32'h3C);
        rd(`DDRRD_OFS_STATUS, v);
        chk("cleared flags", 32'h0, v & 32'h3C);
        ctrl.send(3'h2, 14'h1000, 4'h9);
        ctrl.gap(6);
        ctrl.send(3'h1, 14'h0000, 4'h9);
        ctrl.gap(6);
        ctrl.send(3'h2, 14'h1000, 4'h1);
        rd(`DDRRD_OFS_STATUS, v);
        chk("spacing kept", 32'h0, v & 32'h18);
        ctrl.send(3'h1, 14'h0000, 4'h9);
        ctrl.gap(2);
        ctrl.send(3'h2, 14'h1000, 4'h9);
        rd(`DDRRD_OFS_STATUS, v);
        chk("spacing broken", 32'h18, v & 32'h18);
        ctrl.gap(10);
        $display("test turnaround done");
    endtask

    task t_unlock;
        logic [31:0] v;
        @(posedge clk);
        dll <= 1'b0;
        ctrl.gap(2);
        ctrl.send(3'h2, 14'h1000, 4'h9);
        ctrl.gap(6);
        chk("no burst", 32'h1, {31'h0, dq_oe_n});
        rd(`DDRRD_OFS_STATUS, v);
        chk("unlock flags", 32'h20, v & 32'h22);
        wr(`DDRRD_OFS_STATUS, 32'h20);
        @(posedge clk);
        dll <= 1'b1;
        ctrl.gap(2);
        rd(`DDRRD_OFS_STATUS, v);
        chk("relock flags", 32'h2, v & 32'h22);
        $display("test unlock done");
    endtask

    task summarize;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // The tests need about 1000 cycles; twenty times that means a hang.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            summarize();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_fill();
        t_modes();
        t_turn();
        t_unlock();
        summarize();
    end
endmodule
